//--- ptt_pkg.sv
/*
  ptt_pkg: constants, register map and carrier types of the pattern trigger timing block.
  assumes a 50 MHz system clock; the 107.136 ns delay step is produced by a fractional accumulator.
*/
package ptt_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_IN_DLY = 12'h004;
  localparam logic [11:0] ADDR_OUT1_RISE = 12'h008;
  localparam logic [11:0] ADDR_OUT1_FALL = 12'h00c;
  localparam logic [11:0] ADDR_OUT2_RISE = 12'h010;
  localparam logic [11:0] ADDR_OUT2_PPP = 12'h014;
  localparam logic [11:0] ADDR_LOAD_CTRL = 12'h018;
  localparam logic [11:0] ADDR_LOAD_TIME = 12'h01c;
  localparam logic [11:0] ADDR_STATUS = 12'h020;
  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_INV1 = 0;
  localparam int CTRL_INV2 = 1;
  localparam int LOAD_START = 8;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] PPP_RST = 8'h01;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  // step of 107.136 ns expressed in picoseconds; the clock period in picoseconds
  localparam int STEP_PS = 107136;
  localparam int CLK_PS = 1_000_000_000 / (CLK_HZ / 1000);
  // accumulator: add CLK_PS each cycle, a tick whenever STEP_PS is crossed
  localparam logic [17:0] STEP_PS_W = 18'(STEP_PS);
  localparam logic [17:0] CLK_PS_W = 18'(CLK_PS);
  // signed offsets: lead window -20.05 us = 187 steps, lag +2.79 us = 26 steps, +7.29 us = 68 steps
  localparam int LEAD_NS = 20050;
  // rounded down: the notice comes exactly LEAD_STEPS ticks ahead, so a zero offset lands on the boundary
  localparam logic [8:0] LEAD_STEPS = 9'((LEAD_NS * 1000) / STEP_PS);
  localparam int LOAD_MS = 200;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int LOAD_CYCLES = LOAD_MS * MS_CYCLES;

  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic err;
  } ptt_apb_rsp_s;
endpackage

//--- ptt_pattern_trigger_timing.sv
/*
  ptt_pattern_trigger_timing: trigger input qualification, two trigger outputs and image load timer.
  assumes exposure boundaries are announced ahead by the sequencer (scheduled events) and APB master.
*/
// Added by the designer: the APB register port and the address map.
// Summary of operation
// - delay trigger input rise by programmed steps
// - output one rise offset from exposure start
// - output one fall offset from exposure end
// - output one polarity set by invert bit
// - output two rise offset from exposure start
// - output two polarity set by invert bit
// - output two pulses every N patterns
// - image load reports elapsed milliseconds
// - two buffers, extra images cost reload
`timescale 1ns/1ps
module ptt_pattern_trigger_timing #(
  parameter int LOAD_CYCLES = ptt_pkg::LOAD_CYCLES,
  parameter int MS_CYCLES = ptt_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic triggerInputOne,
  input wire logic exposureStartSoon,
  input wire logic exposureEndSoon,
  output logic triggerInputSeen,
  output logic triggerOutputOne,
  output logic triggerOutputTwo,
  output logic loadBusy
);
  logic [31:0] ctrl_reg;
  logic [17:0] inDly_reg;
  logic [9:0] rise1_reg, fall1_reg, rise2_reg;
  logic [7:0] ppp_reg;
  logic [7:0] loadIdx_reg;
  logic [15:0] loadMs_reg;
  logic [17:0] acc_reg;
  logic tick;
  // ----------------------------------------------------------------
  // step tick
  // ----------------------------------------------------------------
  // fractional accumulation keeps long-run step length exact at 107.136 ns
  wire [17:0] accSum = acc_reg + ptt_pkg::CLK_PS_W;
  wire accWrap = accSum >= ptt_pkg::STEP_PS_W;
  wire [17:0] accNext = accWrap ? accSum - ptt_pkg::STEP_PS_W : accSum;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= 18'h0;
      tick <= 1'b0;
    end else if (clkEn) begin
      acc_reg <= accNext;
      tick <= accWrap;
    end
  end
  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  wire wr = psel && penable && pwrite && pready;
  wire rdAcc = psel && !penable;
  wire hitCtrl = paddr == ptt_pkg::ADDR_CTRL;
  wire hitIn = paddr == ptt_pkg::ADDR_IN_DLY;
  wire hitR1 = paddr == ptt_pkg::ADDR_OUT1_RISE;
  wire hitF1 = paddr == ptt_pkg::ADDR_OUT1_FALL;
  wire hitR2 = paddr == ptt_pkg::ADDR_OUT2_RISE;
  wire hitPpp = paddr == ptt_pkg::ADDR_OUT2_PPP;
  wire hitLc = paddr == ptt_pkg::ADDR_LOAD_CTRL;
  wire hitLt = paddr == ptt_pkg::ADDR_LOAD_TIME;
  wire hitSt = paddr == ptt_pkg::ADDR_STATUS;
  wire hitAny = hitCtrl | hitIn | hitR1 | hitF1 | hitR2 | hitPpp | hitLc | hitLt | hitSt;
  logic [31:0] rdMux;
  logic bufSlot_reg;
  logic [1:0] bufValid_reg;
  logic trigSeen_reg, out1Act_reg, out2Act_reg;
  always_comb begin
    if (hitCtrl) rdMux = ctrl_reg;
    else if (hitIn) rdMux = {14'h0, inDly_reg};
    else if (hitR1) rdMux = {22'h0, rise1_reg};
    else if (hitF1) rdMux = {22'h0, fall1_reg};
    else if (hitR2) rdMux = {22'h0, rise2_reg};
    else if (hitPpp) rdMux = {24'h0, ppp_reg};
    else if (hitLc) rdMux = {24'h0, loadIdx_reg};
    else if (hitLt) rdMux = {16'h0, loadMs_reg};
    else if (hitSt) rdMux = {25'h0, bufSlot_reg, bufValid_reg, out2Act_reg, out1Act_reg, trigSeen_reg, loadBusy};
    else rdMux = 32'h0;
  end
  logic loadStart;
  assign loadStart = wr && hitLc && pwdata[ptt_pkg::LOAD_START];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (clkEn) begin
      pready <= rdAcc;
      pslverr <= rdAcc && !hitAny;
      if (rdAcc) prdata <= rdMux;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= ptt_pkg::CTRL_RST;
      inDly_reg <= 18'h0;
      rise1_reg <= 10'h0;
      fall1_reg <= 10'h0;
      rise2_reg <= 10'h0;
      ppp_reg <= ptt_pkg::PPP_RST;
      loadIdx_reg <= 8'h0;
    end else if (clkEn && wr) begin
      if (hitCtrl) ctrl_reg <= {30'h0, pwdata[1:0]};
      if (hitIn) inDly_reg <= pwdata[17:0];
      if (hitR1) rise1_reg <= pwdata[9:0];
      if (hitF1) fall1_reg <= pwdata[9:0];
      if (hitR2) rise2_reg <= pwdata[9:0];
      if (hitPpp) ppp_reg <= (pwdata[7:0] == 8'h0) ? 8'h01 : pwdata[7:0];
      if (hitLc && !loadBusy) loadIdx_reg <= pwdata[7:0];
    end
  end
  // ----------------------------------------------------------------
  // trigger input delay
  // ----------------------------------------------------------------
  logic trigPrev_reg, trigWait_reg;
  logic [17:0] inCnt_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trigPrev_reg <= 1'b0;
      trigWait_reg <= 1'b0;
      inCnt_reg <= 18'h0;
      trigSeen_reg <= 1'b0;
    end else if (clkEn) begin
      trigPrev_reg <= triggerInputOne;
      trigSeen_reg <= 1'b0;
      if (triggerInputOne && !trigPrev_reg && !trigWait_reg) begin
        trigWait_reg <= 1'b1;
        inCnt_reg <= inDly_reg;
        if (inDly_reg == 18'h0) begin
          trigWait_reg <= 1'b0;
          trigSeen_reg <= 1'b1;
        end
      end else if (trigWait_reg && tick) begin
        if (inCnt_reg <= 18'h1) begin
          trigWait_reg <= 1'b0;
          trigSeen_reg <= 1'b1;
        end
        inCnt_reg <= inCnt_reg - 18'h1;
      end
    end
  end
  assign triggerInputSeen = trigSeen_reg;
  // ----------------------------------------------------------------
  // edge schedulers
  // ----------------------------------------------------------------
  // offsets are signed step counts; the sequencer announces each boundary LEAD_STEPS ticks early,
  // so the edge fires after LEAD_STEPS + offset ticks from that notice
  wire [10:0] rise1Wait = 11'(ptt_pkg::LEAD_STEPS) + {rise1_reg[9], rise1_reg};
  wire [10:0] fall1Wait = 11'(ptt_pkg::LEAD_STEPS) + {fall1_reg[9], fall1_reg};
  wire [10:0] rise2Wait = 11'(ptt_pkg::LEAD_STEPS) + {rise2_reg[9], rise2_reg};
  logic [10:0] r1Cnt_reg, f1Cnt_reg, r2Cnt_reg, f2Cnt_reg;
  logic r1Arm_reg, f1Arm_reg, r2Arm_reg, f2Arm_reg;
  logic [7:0] patCnt_reg;
  wire pulseDue = patCnt_reg == 8'h0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r1Cnt_reg <= 11'h0;
      f1Cnt_reg <= 11'h0;
      r2Cnt_reg <= 11'h0;
      f2Cnt_reg <= 11'h0;
      r1Arm_reg <= 1'b0;
      f1Arm_reg <= 1'b0;
      r2Arm_reg <= 1'b0;
      f2Arm_reg <= 1'b0;
      out1Act_reg <= 1'b0;
      out2Act_reg <= 1'b0;
      patCnt_reg <= 8'h0;
    end else if (clkEn) begin
      if (exposureStartSoon) begin
        r1Arm_reg <= 1'b1;
        r1Cnt_reg <= rise1Wait;
        if (pulseDue) begin
          r2Arm_reg <= 1'b1;
          r2Cnt_reg <= rise2Wait;
        end
        patCnt_reg <= pulseDue ? ppp_reg - 8'h1 : patCnt_reg - 8'h1;
      end else if (tick) begin
        if (r1Arm_reg) r1Cnt_reg <= r1Cnt_reg - 11'h1;
        if (r2Arm_reg) r2Cnt_reg <= r2Cnt_reg - 11'h1;
      end
      if (exposureEndSoon) begin
        f1Arm_reg <= 1'b1;
        f1Cnt_reg <= fall1Wait;
        f2Arm_reg <= out2Act_reg || r2Arm_reg;
        f2Cnt_reg <= fall1Wait;
      end else if (tick) begin
        if (f1Arm_reg) f1Cnt_reg <= f1Cnt_reg - 11'h1;
        if (f2Arm_reg) f2Cnt_reg <= f2Cnt_reg - 11'h1;
      end
      if (r1Arm_reg && r1Cnt_reg == 11'h0) begin
        r1Arm_reg <= 1'b0;
        out1Act_reg <= 1'b1;
      end
      if (f1Arm_reg && f1Cnt_reg == 11'h0) begin
        f1Arm_reg <= 1'b0;
        out1Act_reg <= 1'b0;
      end
      if (r2Arm_reg && r2Cnt_reg == 11'h0) begin
        r2Arm_reg <= 1'b0;
        out2Act_reg <= 1'b1;
      end
      if (f2Arm_reg && f2Cnt_reg == 11'h0) begin
        f2Arm_reg <= 1'b0;
        out2Act_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      triggerOutputOne <= 1'b0;
      triggerOutputTwo <= 1'b0;
    end else if (clkEn) begin
      triggerOutputOne <= out1Act_reg ^ ctrl_reg[ptt_pkg::CTRL_INV1];
      triggerOutputTwo <= out2Act_reg ^ ctrl_reg[ptt_pkg::CTRL_INV2];
    end
  end
  // ----------------------------------------------------------------
  // image load timing
  // ----------------------------------------------------------------
  // the flash copy itself is modelled as a fixed LOAD_CYCLES busy window; the measured
  // time is a single sample, not an average
  logic [31:0] loadCnt_reg;
  logic [31:0] msCnt_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loadBusy <= 1'b0;
      loadCnt_reg <= 32'h0;
      msCnt_reg <= 32'h0;
      loadMs_reg <= 16'h0;
      bufSlot_reg <= 1'b0;
      bufValid_reg <= 2'h0;
    end else if (clkEn) begin
      if (loadStart && !loadBusy) begin
        loadBusy <= 1'b1;
        loadCnt_reg <= 32'(LOAD_CYCLES);
        msCnt_reg <= 32'h0;
        loadMs_reg <= 16'h0;
      end else if (loadBusy) begin
        loadCnt_reg <= loadCnt_reg - 32'h1;
        if (msCnt_reg == 32'(MS_CYCLES - 1)) begin
          msCnt_reg <= 32'h0;
          loadMs_reg <= loadMs_reg + 16'h1;
        end else begin
          msCnt_reg <= msCnt_reg + 32'h1;
        end
        if (loadCnt_reg == 32'h1) begin
          loadBusy <= 1'b0;
          bufValid_reg[bufSlot_reg] <= 1'b1;
          bufSlot_reg <= ~bufSlot_reg;
        end
      end
    end
  end
endmodule

//--- ptt_sva.sv
/*
  ptt_sva: port assertions for the pattern trigger timing block.
  assumes clkEn held high and exposure notices spaced well apart.
*/
`timescale 1ns/1ps
module ptt_sva #(
  parameter int LOAD_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic triggerInputOne,
  input wire logic exposureStartSoon,
  input wire logic exposureEndSoon,
  input wire logic triggerInputSeen,
  input wire logic triggerOutputOne,
  input wire logic triggerOutputTwo,
  input wire logic loadBusy
);
  localparam int LO = LOAD_CYCLES - 2;
  localparam int HI = LOAD_CYCLES + 2;
  logic [31:0] sh [0:4];
  logic [15:0] cS, cE, cI, cB;
  logic [2:0] q;
  wire wr = psel && penable && pready && pwrite;
  wire a1 = triggerOutputOne ^ sh[0][0];
  wire a2 = triggerOutputTwo ^ sh[0][1];
  // cS, cE and cI saturate so a stray edge long after any notice lands outside every window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 5; i++) sh[i] <= 32'h0;
      {cS, cE, cI} <= {48{1'b1}};
      cB <= 16'h0;
      q <= 3'h7;
    end else begin
      if (wr && paddr < 12'h014) sh[paddr[4:2]] <= pwdata;
      q <= (wr && paddr == ptt_pkg::ADDR_CTRL) ? 3'h0 : ((q == 3'h7) ? q : q + 3'h1);
      cS <= exposureStartSoon ? 16'h0 : ((&cS) ? cS : cS + 16'h1);
      cE <= exposureEndSoon ? 16'h0 : ((&cE) ? cE : cE + 16'h1);
      cI <= $rose(triggerInputOne) ? 16'h0 : ((&cI) ? cI : cI + 16'h1);
      cB <= loadBusy ? cB + 16'h1 : 16'h0;
    end
  end
  // a tick averages 5.36 clocks and the first may come one cycle after the notice,
  // so n ticks fall between 5n-4 and 6n cycles plus pipeline
  function automatic logic inWin(input logic [15:0] c, input int t);
    return int'(c) >= t * 5 - 4 && int'(c) <= t * 6 + 8;
  endfunction
  function automatic int lead(input logic [31:0] off);
    return int'(ptt_pkg::LEAD_STEPS) + int'($signed(off[9:0]));
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_OUT1_RISE: assert property ($rose(a1) && q == 3'h7 |-> inWin(cS, lead(sh[2])))
    else $error("output one rise outside its window");
  AST_OUT1_FALL: assert property ($fell(a1) && q == 3'h7 |-> inWin(cE, lead(sh[3])))
    else $error("output one fall outside its window");
  AST_OUT2_RISE: assert property ($rose(a2) && q == 3'h7 |-> inWin(cS, lead(sh[4])))
    else $error("output two rise outside its window");
  AST_POL_ONE: assert property ($changed(sh[0][0]) |-> ##[1:3] triggerOutputOne == sh[0][0])
    else $error("output one idle level wrong");
  AST_POL_TWO: assert property ($changed(sh[0][1]) |-> ##[1:3] triggerOutputTwo == sh[0][1])
    else $error("output two idle level wrong");
  AST_SEEN_WIN: assert property (triggerInputSeen |-> inWin(cI, int'(sh[1][17:0])))
    else $error("input trigger seen at wrong delay");
  AST_SEEN_PULSE: assert property (triggerInputSeen |=> !triggerInputSeen)
    else $error("input seen longer than one cycle");
  AST_LOAD_START: assert property (wr && paddr == ptt_pkg::ADDR_LOAD_CTRL && pwdata[ptt_pkg::LOAD_START] && !loadBusy
    |-> ##[1:3] loadBusy)
    else $error("load did not start");
  AST_LOAD_LEN: assert property ($fell(loadBusy) |-> cB >= LO && cB <= HI)
    else $error("load length wrong");
  AST_LOAD_END: assert property ($rose(loadBusy) |-> ##[1:HI] !loadBusy)
    else $error("load never ended");
  cover property ($rose(a1));
  cover property ($rose(a2));
  cover property (triggerInputSeen);
  cover property ($fell(loadBusy));
endmodule

//--- ptt_cam_model.sv
/*
  ptt_cam_model: camera on the trigger pins; counts active pulses and raises the trigger input.
  assumes the invert settings are mirrored by the bench.
*/
`timescale 1ns/1ps
module ptt_cam_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic [1:0] inv,
  input wire logic triggerOutputOne,
  input wire logic triggerOutputTwo,
  output logic triggerInputOne,
  output logic [7:0] pulsesOne,
  output logic [7:0] pulsesTwo
);
  logic a1Reg, a2Reg;
  wire a1 = triggerOutputOne ^ inv[0];
  wire a2 = triggerOutputTwo ^ inv[1];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {a1Reg, a2Reg, triggerInputOne, pulsesOne, pulsesTwo} <= 19'h0;
    end else begin
      a1Reg <= a1;
      a2Reg <= a2;
      triggerInputOne <= fire;
      pulsesOne <= pulsesOne + 8'(a1 && !a1Reg);
      pulsesTwo <= pulsesTwo + 8'(a2 && !a2Reg);
    end
  end
endmodule

//--- tb.sv
/*
  tb: self-checking bench for the pattern trigger timing block.
  assumes zero-wait apb answers and shortened load timing.
*/
`timescale 1ns/1ps
module tb;
  localparam int LC = 200;
  localparam int MC = 10;
  logic clk, rst, psel, penable, pwrite, startSoon, endSoon, fire;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic pready, pslverr, trigIn, seen, out1, out2, loadBusy;
  logic [1:0] inv;
  logic [7:0] p1, p2, n1, n2;
  logic [32:0] expQ[$];
  int miscompares, checksDone, cyc, nSeen;
  ptt_pattern_trigger_timing #(.LOAD_CYCLES(LC), .MS_CYCLES(MC)) i_dut (.clk, .rst, .clkEn(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .triggerInputOne(trigIn),
    .exposureStartSoon(startSoon), .exposureEndSoon(endSoon), .triggerInputSeen(seen),
    .triggerOutputOne(out1), .triggerOutputTwo(out2), .loadBusy);
  ptt_cam_model i_cam (.clk, .rst, .fire, .inv, .triggerOutputOne(out1), .triggerOutputTwo(out2),
    .triggerInputOne(trigIn), .pulsesOne(p1), .pulsesTwo(p2));
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    checksDone++;
    if (e !== g) begin
      miscompares++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    // one idle edge so the next call never reassigns psel in this time step
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic e, input logic [31:0] d);
    expQ.push_back({e, d});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pattern();
    startSoon <= 1'b1;
    @(posedge clk) startSoon <= 1'b0;
    // exposure long enough that both rise edges land before the falls that the end notice schedules
    repeat (600) @(posedge clk);
    endSoon <= 1'b1;
    @(posedge clk) endSoon <= 1'b0;
    repeat (1500) @(posedge clk);
  endtask
  // read data is compared at the same edge the master takes it
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk(expQ.pop_front(), {pslverr, prdata});
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, startSoon, endSoon, fire, inv} = {1'b1, 52'h0};
    void'($urandom(32'h2211b7d3));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(ptt_pkg::ADDR_CTRL, 1'b0, ptt_pkg::CTRL_RST);
    rd(ptt_pkg::ADDR_OUT2_PPP, 1'b0, 32'(ptt_pkg::PPP_RST));
    rd(12'h024, 1'b1, 32'h0);
    apb(1'b1, 12'h024, 32'hffff_ffff);
    // signed offset across the whole lead and lag range
    v = 32'($urandom_range(213, 0)) - 32'd187;
    apb(1'b1, ptt_pkg::ADDR_OUT1_RISE, v);
    rd(ptt_pkg::ADDR_OUT1_RISE, 1'b0, {22'h0, v[9:0]});
    apb(1'b1, ptt_pkg::ADDR_OUT2_RISE, 32'd68);
    rd(ptt_pkg::ADDR_OUT2_RISE, 1'b0, 32'd68);
    apb(1'b1, ptt_pkg::ADDR_OUT2_PPP, 32'h0);
    rd(ptt_pkg::ADDR_OUT2_PPP, 1'b0, 32'h1);
    apb(1'b1, ptt_pkg::ADDR_OUT2_PPP, 32'h2);
    // every polarity pair, idle level must equal the invert bit
    for (int i = 0; i < 5; i++) begin
      inv <= 2'(i);
      apb(1'b1, ptt_pkg::ADDR_CTRL, 32'(i % 4));
      repeat (4) @(posedge clk);
      chk(33'(i % 4), {31'h0, out2, out1});
    end
    n1 = p1;
    n2 = p2;
    repeat (3) pattern();
    chk(33'(n1 + 8'd3), 33'(p1));
    chk(33'(n2 + 8'd2), 33'(p2));
    v = $urandom_range(20, 4);
    apb(1'b1, ptt_pkg::ADDR_IN_DLY, v);
    rd(ptt_pkg::ADDR_IN_DLY, 1'b0, v);
    fire <= 1'b1;
    repeat (200) begin
      @(posedge clk);
      if (seen === 1'b1) nSeen++;
    end
    fire <= 1'b0;
    chk(33'd1, 33'(nSeen));
    apb(1'b1, ptt_pkg::ADDR_LOAD_CTRL, 32'h0000_0105);
    apb(1'b1, ptt_pkg::ADDR_LOAD_CTRL, 32'h0000_0107);
    @(posedge clk);
    chk(33'd1, 33'(loadBusy));
    repeat (400) begin
      @(posedge clk);
      if (loadBusy === 1'b0) break;
    end
    rd(ptt_pkg::ADDR_LOAD_TIME, 1'b0, 32'(LC / MC));
    rd(ptt_pkg::ADDR_LOAD_CTRL, 1'b0, 32'h0000_0005);
    rd(ptt_pkg::ADDR_STATUS, 1'b0, 32'h0000_0050);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule
bind ptt_pattern_trigger_timing ptt_sva #(.LOAD_CYCLES(LOAD_CYCLES)) i_sva (.clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .triggerInputOne, .exposureStartSoon, .exposureEndSoon,
  .triggerInputSeen, .triggerOutputOne, .triggerOutputTwo, .loadBusy);
